// ==== c8cc_core.sv ====
// c8cc_core: 8-bit up/down timer counter with one double-buffered compare unit
// assumes software-side strobes are single-cycle and synchronous to clock
`timescale 1ns/1ps

// Contract
// - counter and compare are 8-bit read/write registers
// - every timer request visible as a flag
// - each request masked separately; flag still sets
// - clock from prescaler or external pin
// - select chooses source and active edge
// - no source selected: counter holds unless software writes it
// - double-buffered compare checked on every timer tick
// - compare drives pwm or frequency output
// - compare match sets compare match flag
// - bottom signalled at 0x00
// - max signalled at 0xFF
// - top is 0xFF or compare, per mode
// - clock select field in control register
// - count changes counter by exactly one
// - direction picks increment or decrement
// - clear forces all counter bits zero
// - clear-on-match mode reloads from zero
// - two sources: overflow and compare match
// - select zero stops timer, access still works
// - software counter write beats clear/count
// - match flag set on following tick
// - writing one clears compare match flag
module c8cc_core
  import c8cc_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // timer control register
  input  wire c8cc_pkg::c8cc_ctrl_t    timer_control_reg,
  // counter value access
  input  wire logic                    counter_wr,
  input  wire logic [7:0]              counter_wdata,
  output logic [7:0]                   counter_value,
  // compare value access
  input  wire logic                    compare_wr,
  input  wire logic [7:0]              compare_wdata,
  output logic [7:0]                   compare_value,
  // flags and mask
  input  wire c8cc_pkg::c8cc_flags_t   timer_mask_reg,
  input  wire logic                    flag_wr,
  input  wire c8cc_pkg::c8cc_flags_t   flag_wdata,
  output c8cc_pkg::c8cc_flags_t        timer_flag_reg,
  output logic                         overflow_irq,
  output logic                         compare_irq,
  // pins and status
  input  wire logic                    external_count_pin,
  output logic                         compare_output_pin,
  output logic                         timer_tick,
  output logic                         at_bottom,
  output logic                         at_max,
  output logic                         at_top
);
  import c8cc_pkg::*;

  // ==========================================================
  // external pin synchroniser
  logic [2:0]        ext_sync_r;
  logic              ext_level_r;
  logic              ext_rise;
  logic              ext_fall;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ext_sync_r  <= 3'h0;
      ext_level_r <= 1'b0;
    end
    else
    begin
      ext_sync_r <= {ext_sync_r[1:0], external_count_pin};
      if (ext_sync_r[1] == ext_sync_r[2])
        ext_level_r <= ext_sync_r[2];
    end
  end

  assign ext_rise = ext_sync_r[1] & ext_sync_r[2] & ~ext_level_r;
  assign ext_fall = ~ext_sync_r[1] & ~ext_sync_r[2] & ext_level_r;

  // ==========================================================
  // prescaler and clock select
  logic [PRE_W-1:0]  pre_r;
  logic [PRE_W-1:0]  pre_nxt;
  logic              tick;

  assign pre_nxt = pre_r + 10'h001;

  // free-running; taps fire when all lower bits roll over
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pre_r <= '0;
    else
      pre_r <= pre_nxt;
  end

  // source and edge picked by the select field
  always_comb
  begin
    case (timer_control_reg.clock_source_select)
      CS_NONE:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = pre_nxt[TAP_DIV8:0] == '0;
      CS_DIV64:    tick = pre_nxt[TAP_DIV64:0] == '0;
      CS_DIV256:   tick = pre_nxt[TAP_DIV256:0] == '0;
      CS_DIV1024:  tick = pre_nxt[TAP_DIV1024:0] == '0;
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  assign timer_tick = tick;

  // ==========================================================
  // top, direction and compare buffering
  logic [7:0]        cmp_buf_r;
  logic [7:0]        cmp_act_r;
  logic [7:0]        top_val;
  logic              pwm_mode;
  logic              dir_down_r;
  logic [7:0]        cnt_r;

  assign pwm_mode = (timer_control_reg.mode == C8CC_PWM_PC) ||
                    (timer_control_reg.mode == C8CC_PWM_FAST);
  // only clear-on-match uses the compare value as top
  assign top_val  = (timer_control_reg.mode == C8CC_CTC) ? cmp_act_r : MAX_VAL;

  assign at_bottom = cnt_r == BOTTOM_VAL;
  assign at_max    = cnt_r == MAX_VAL;
  assign at_top    = cnt_r == top_val;

  // buffered in pwm modes so pulses never come out odd-length
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cmp_buf_r <= CMP_RESET;
      cmp_act_r <= CMP_RESET;
    end
    else
    begin
      if (compare_wr)
        cmp_buf_r <= compare_wdata;
      if (!pwm_mode && compare_wr)
        cmp_act_r <= compare_wdata;
      else if (pwm_mode && tick && at_top && timer_control_reg.mode == C8CC_PWM_FAST)
        cmp_act_r <= cmp_buf_r;
      else if (pwm_mode && tick && at_max && timer_control_reg.mode == C8CC_PWM_PC)
        cmp_act_r <= cmp_buf_r;
      else if (!pwm_mode)
        cmp_act_r <= cmp_buf_r;
    end
  end

  assign compare_value = pwm_mode ? cmp_buf_r : cmp_act_r;

  // ==========================================================
  // counter unit: count, direction, clear
  logic              do_clear;
  logic              do_count;
  logic              match;
  logic              overflow_evt;

  assign match = cnt_r == cmp_act_r;

  // phase-correct turns round at max; at bottom the direction clears but the count still steps down to 0xFF
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      dir_down_r <= 1'b0;
    else if (timer_control_reg.mode != C8CC_PWM_PC)
      dir_down_r <= 1'b0;
    else if (tick && at_max)
      dir_down_r <= 1'b1;
    else if (tick && at_bottom)
      dir_down_r <= 1'b0;
  end

  assign do_clear = tick && (timer_control_reg.mode == C8CC_CTC) && match;
  assign do_count = tick && !do_clear;

  // software write wins; clear beats count; only a write moves it without a tick
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cnt_r <= CNT_RESET;
    else if (counter_wr)
      cnt_r <= counter_wdata;
    else if (do_clear)
      cnt_r <= BOTTOM_VAL;
    else if (do_count && (dir_down_r ^ (timer_control_reg.mode == C8CC_PWM_PC && at_max)))
      cnt_r <= cnt_r - 8'h01;
    else if (do_count)
      cnt_r <= cnt_r + 8'h01;
  end

  assign counter_value = cnt_r;

  // overflow per mode: phase-correct at bottom, others wrapping from max
  assign overflow_evt = tick && ((timer_control_reg.mode == C8CC_PWM_PC) ?
                        (at_bottom && dir_down_r) : at_max) && !counter_wr;

  // ==========================================================
  // match blocking and flags
  logic              block_r;
  logic              match_evt;
  logic              ovf_flag_r;
  logic              cmp_flag_r;

  // a counter write blocks the match of the next tick, even when stopped
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      block_r <= 1'b0;
    else if (counter_wr)
      block_r <= 1'b1;
    else if (tick)
      block_r <= 1'b0;
  end

  // flag set on the tick that follows the equal cycle
  assign match_evt = tick && match && !block_r && !counter_wr;

  // set wins over a simultaneous write-one clear
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cmp_flag_r <= 1'b0;
    else if (match_evt)
      cmp_flag_r <= 1'b1;
    else if (flag_wr && flag_wdata.compare_match_flag)
      cmp_flag_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      ovf_flag_r <= 1'b0;
    else if (overflow_evt)
      ovf_flag_r <= 1'b1;
    else if (flag_wr && flag_wdata.overflow_flag)
      ovf_flag_r <= 1'b0;
  end

  assign timer_flag_reg.compare_match_flag = cmp_flag_r;
  assign timer_flag_reg.overflow_flag      = ovf_flag_r;
  assign compare_irq  = cmp_flag_r & timer_mask_reg.compare_match_flag;
  assign overflow_irq = ovf_flag_r & timer_mask_reg.overflow_flag;

  // ==========================================================
  // waveform generator
  logic              wave_r;

  // non-pwm acts on match; fast pwm sets at bottom in clear mode, clears otherwise; phase-correct by direction
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      wave_r <= 1'b0;
    else if (pwm_mode && tick)
    begin
      if (timer_control_reg.mode == C8CC_PWM_FAST && at_max)
        wave_r <= (timer_control_reg.out_mode == C8CC_OUT_CLEAR);
      else if (match_evt)
        wave_r <= dir_down_r ^ (timer_control_reg.out_mode == C8CC_OUT_SET);
    end
    else if (match_evt)
    begin
      case (timer_control_reg.out_mode)
        C8CC_OUT_TOGGLE: wave_r <= ~wave_r;
        C8CC_OUT_CLEAR:  wave_r <= 1'b0;
        C8CC_OUT_SET:    wave_r <= 1'b1;
        default:         wave_r <= wave_r;
      endcase
    end
  end

  // off mode releases the pin back to its port value (low here)
  assign compare_output_pin = (timer_control_reg.out_mode == C8CC_OUT_OFF) ? 1'b0 : wave_r;

endmodule

// ==== c8cc_core_properties.sv ====
// c8cc_core_properties: port-level checks of the counter/compare core
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ps
module c8cc_core_properties
  import c8cc_pkg::*;
(
  // clock and reset
  input wire logic                  clock,
  input wire logic                  sys_rst,
  // controls
  input wire c8cc_pkg::c8cc_ctrl_t  timer_control_reg,
  input wire logic                  counter_wr,
  input wire logic [7:0]            counter_wdata,
  input wire c8cc_pkg::c8cc_flags_t timer_mask_reg,
  input wire logic                  flag_wr,
  input wire c8cc_pkg::c8cc_flags_t flag_wdata,
  // outputs
  input wire logic [7:0]            counter_value,
  input wire logic [7:0]            compare_value,
  input wire c8cc_pkg::c8cc_flags_t timer_flag_reg,
  input wire logic                  overflow_irq,
  input wire logic                  compare_irq,
  input wire logic                  compare_output_pin,
  input wire logic                  timer_tick,
  input wire logic                  at_bottom,
  input wire logic                  at_max
);
  logic blk_r;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========
  // a counter write blocks the match of the next tick
  always_ff @(posedge clock)
    if (sys_rst) blk_r <= 1'b0;
    else if (counter_wr) blk_r <= 1'b1;
    else if (timer_tick) blk_r <= 1'b0;
  property p_ovf_irq; overflow_irq == (timer_flag_reg.overflow_flag & timer_mask_reg.overflow_flag); endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request mismatch");
  property p_cmp_irq; compare_irq == (timer_flag_reg.compare_match_flag & timer_mask_reg.compare_match_flag); endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare request mismatch");
  property p_bottom; at_bottom == (counter_value == 8'h00); endproperty
  a_bottom: assert property (p_bottom) else $error("bottom status wrong");
  property p_max; at_max == (counter_value == 8'hFF); endproperty
  a_max: assert property (p_max) else $error("max status wrong");
  property p_stop; timer_control_reg.clock_source_select == CS_NONE |-> !timer_tick; endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");
  property p_hold; !timer_tick && !counter_wr |=> $stable(counter_value); endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");
  property p_wr; counter_wr |=> counter_value == $past(counter_wdata); endproperty
  a_wr: assert property (p_wr) else $error("counter write lost");
  property p_inc; timer_tick && !counter_wr && timer_control_reg.mode == C8CC_NORMAL
    |=> counter_value == $past(counter_value) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("count step wrong");
  property p_match; timer_tick && !counter_wr && !blk_r && counter_value == compare_value
    && timer_control_reg.mode inside {C8CC_NORMAL, C8CC_CTC} |=> timer_flag_reg.compare_match_flag; endproperty
  a_match: assert property (p_match) else $error("match flag not set");
  property p_clr; flag_wr && flag_wdata.compare_match_flag && !timer_tick
    |=> !timer_flag_reg.compare_match_flag; endproperty
  a_clr: assert property (p_clr) else $error("match flag not cleared");
  property p_pin_off; (timer_control_reg.out_mode == C8CC_OUT_OFF) [*2] |-> !compare_output_pin; endproperty
  a_pin_off: assert property (p_pin_off) else $error("output pin active while off");
endmodule

bind c8cc_core c8cc_core_properties u_c8cc_core_properties (
  .clock, .sys_rst, .timer_control_reg, .counter_wr, .counter_wdata, .timer_mask_reg,
  .flag_wr, .flag_wdata, .counter_value, .compare_value, .timer_flag_reg, .overflow_irq,
  .compare_irq, .compare_output_pin, .timer_tick, .at_bottom, .at_max);

// ==== c8cc_pkg.sv ====
// c8cc_pkg: constants and carrier types for the 8-bit counter/compare core
// assumes one 200 MHz system clock and synchronous active-high reset
package c8cc_pkg;

  // ==========================================================
  // widths and reset values
  localparam int             CNT_W         = 8;
  localparam logic [7:0]     BOTTOM_VAL    = 8'h00;
  localparam logic [7:0]     MAX_VAL       = 8'hFF;
  localparam logic [7:0]     CNT_RESET     = 8'h00;
  localparam logic [7:0]     CMP_RESET     = 8'h00;

  // ==========================================================
  // clock select encodings
  localparam logic [2:0]     CS_NONE       = 3'h0;
  localparam logic [2:0]     CS_DIV1       = 3'h1;
  localparam logic [2:0]     CS_DIV8       = 3'h2;
  localparam logic [2:0]     CS_DIV64      = 3'h3;
  localparam logic [2:0]     CS_DIV256     = 3'h4;
  localparam logic [2:0]     CS_DIV1024    = 3'h5;
  localparam logic [2:0]     CS_EXT_FALL   = 3'h6;
  localparam logic [2:0]     CS_EXT_RISE   = 3'h7;

  // prescaler taps, as bit index of a free-running 10-bit counter
  localparam int             PRE_W         = 10;
  localparam int             TAP_DIV8      = 2;
  localparam int             TAP_DIV64     = 5;
  localparam int             TAP_DIV256    = 7;
  localparam int             TAP_DIV1024   = 9;

  // ==========================================================
  // waveform modes
  typedef enum logic [1:0] {
    C8CC_NORMAL,
    C8CC_PWM_PC,
    C8CC_CTC,
    C8CC_PWM_FAST
  } c8cc_mode_t;

  // compare output actions
  typedef enum logic [1:0] {
    C8CC_OUT_OFF,
    C8CC_OUT_TOGGLE,
    C8CC_OUT_CLEAR,
    C8CC_OUT_SET
  } c8cc_out_t;

  // timer control register fields
  typedef struct packed {
    c8cc_mode_t  mode;
    c8cc_out_t   out_mode;
    logic [2:0]  clock_source_select;
  } c8cc_ctrl_t;

  // flag / mask layout
  typedef struct packed {
    logic        compare_match_flag;
    logic        overflow_flag;
  } c8cc_flags_t;

endpackage

// ==== tb.sv ====
// tb: self-checking bench of the counter/compare core
// assumes the core alone; inputs change on falling edges
`timescale 1ns/1ps
module tb;
  import c8cc_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  c8cc_ctrl_t  ctrl = '0;
  logic        counter_wr = 1'b0, compare_wr = 1'b0, flag_wr = 1'b0, ext_pin = 1'b0;
  logic [7:0]  counter_wdata = 8'h00, compare_wdata = 8'h00, counter_value, compare_value, seen, v;
  c8cc_flags_t mask = '0, flag_wdata = '0, flags;
  logic        ovf_irq, cmp_irq, out_pin, tick, bot, mx, top;
  logic [10:0] exp_q[$];
  logic [10:0] e;
  string       kn[5] = '{"counter", "compare", "flags", "irqs", "status"};
  int          n_mismatch = 0, total_checks = 0, cyc_n = 0, k, seed = 32'hE8243783;
  // ==========
  initial forever #2.5 clock = ~clock;
  c8cc_core u_c8cc_core (.clock(clock), .sys_rst(sys_rst), .timer_control_reg(ctrl),
    .counter_wr(counter_wr), .counter_wdata(counter_wdata), .counter_value(counter_value),
    .compare_wr(compare_wr), .compare_wdata(compare_wdata), .compare_value(compare_value),
    .timer_mask_reg(mask), .flag_wr(flag_wr), .flag_wdata(flag_wdata), .timer_flag_reg(flags),
    .overflow_irq(ovf_irq), .compare_irq(cmp_irq), .external_count_pin(ext_pin),
    .compare_output_pin(out_pin), .timer_tick(tick), .at_bottom(bot), .at_max(mx), .at_top(top));
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic note(input int t, input logic [7:0] x);
    exp_q.push_back({t[2:0], x});
  endtask
  // one-cycle strobe: 0 counter, 1 compare, 2 flag clear
  // only the strobe in use is touched, so back-to-back calls never hit one signal twice
  task automatic wr(input int t, input logic [7:0] x);
    counter_wdata = x;
    compare_wdata = x;
    flag_wdata = x[1:0];
    if (t == 0) counter_wr = 1'b1;
    else if (t == 1) compare_wr = 1'b1;
    else flag_wr = 1'b1;
    cyc(1);
    if (t == 0) counter_wr = 1'b0;
    else if (t == 1) compare_wr = 1'b0;
    else flag_wr = 1'b0;
  endtask
  task automatic stop_test;
    $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // pre-edge values are settled, so notes queued at the falling edge compare cleanly
  always @(posedge clock)
  begin
    cyc_n++;
    if (cyc_n == 3000)
    begin
      n_mismatch++;
      stop_test;
    end
    while (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      case (e[10:8])
        3'h0: seen = counter_value;
        3'h1: seen = compare_value;
        3'h2: seen = {6'h00, flags};
        3'h3: seen = {6'h00, ovf_irq, cmp_irq};
        default: seen = {4'h0, out_pin, bot, mx, top};
      endcase
      total_checks++;
      if (seen !== e[7:0])
      begin
        n_mismatch++;
        $display("CHECK FAILED %s expected %h seen %h", kn[e[10:8]], e[7:0], seen);
      end
    end
  end
  // main sequence
  initial
  begin
    cyc(20);
    sys_rst = 1'b0;
    note(0, 8'h00);
    note(1, 8'h00);
    note(2, 8'h00);
    repeat (4)
    begin
      v = 8'($random(seed));
      wr(0, v);
      note(0, v);
      wr(1, ~v);
      note(1, ~v);
    end
    cyc(10);
    note(0, v);
    // count through the wrap; the write wins over the count of its edge
    wr(1, 8'h80);
    mask = 2'b01;
    ctrl.clock_source_select = CS_DIV1;
    wr(0, 8'hFD);
    for (int i = 0; i < 5; i++)
    begin
      note(0, 8'hFD + i[7:0]);
      if (i == 2) note(4, 8'h03);
      if (i == 3) note(4, 8'h04);
      if (i == 3) note(2, 8'h01);
      if (i == 3) note(3, 8'h02);
      cyc(1);
    end
    ctrl.clock_source_select = CS_NONE;
    mask = 2'b00;
    cyc(1);
    note(3, 8'h00);
    note(2, 8'h01);
    wr(2, 8'h01);
    note(2, 8'h00);
    // clear on match with top at the compare value
    ctrl = '{C8CC_CTC, C8CC_OUT_TOGGLE, CS_NONE};
    mask = 2'b10;
    wr(1, 8'h05);
    wr(0, 8'h00);
    ctrl.clock_source_select = CS_DIV1;
    for (int i = 1; i < 8; i++)
    begin
      cyc(1);
      note(0, (i < 6) ? i[7:0] : i[7:0] - 8'h06);
      if (i == 5) note(4, 8'h01);
      if (i == 6) note(2, 8'h02);
      if (i == 6) note(3, 8'h01);
      if (i == 6) note(4, 8'h0C);
    end
    ctrl.clock_source_select = CS_NONE;
    wr(2, 8'h02);
    note(2, 8'h00);
    // prescaled ticks: any 64 edges hold exactly eight divide-by-8 ticks
    ctrl = '{C8CC_NORMAL, C8CC_OUT_CLEAR, CS_NONE};
    wr(0, 8'h00);
    ctrl.clock_source_select = CS_DIV8;
    cyc(64);
    note(0, 8'h08);
    note(2, 8'h02);
    note(4, 8'h00);
    // external pin: ending high leaves one more rise than falls
    // normal mode, so up to six ticks cannot be cut short by a clear on match
    for (int j = 0; j < 2; j++)
    begin
      ctrl = '{C8CC_NORMAL, C8CC_OUT_CLEAR, CS_NONE};
      ext_pin = 1'b0;
      cyc(8);
      wr(0, 8'h00);
      ctrl.clock_source_select = j ? CS_EXT_RISE : CS_EXT_FALL;
      k = 2 + ($random(seed) & 3);
      repeat (k)
      begin
        ext_pin = 1'b1;
        cyc(8);
        ext_pin = 1'b0;
        cyc(8);
      end
      ext_pin = 1'b1;
      cyc(8);
      note(0, k[7:0] + j[7:0]);
    end
    cyc(2);
    stop_test;
  end
endmodule
